// file: verilog/crb_core_regs.sv
// Working register banks, bit addressing, stack pointer and data pointer
//
// Contract
// - Four banks of eight 8-bit registers
// - Bank select bits choose one active bank
// - First two bank registers serve as pointers
// - Locations 20h-2Fh byte and bit addressable
// - Bit or byte chosen by instruction type
// - Existing SFR bit addressable at nibble 0/8
// - Stack pointer resets to 07h, then writable
// - Push increments pointer, then writes data
// - Pop reads entry, then decrements pointer
// - Call, jump, interrupt push return address; here only call_i pushes one
// - No restriction on stack pointer value
// - Stack pointer is SFR at 81h
// - Data pointer low byte at 82h
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "crb_map.svh"
module crb_core_regs (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Byte access port (direct addresses, SFRs at 80h and up)
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Bit access port
   input wire logic [7:0] bit_addr_i,
   input wire logic bit_wr_i,
   input wire logic bit_rd_i,
   input wire logic bit_wdata_i,
   output logic bit_rdata_o,
   output logic bit_valid_o,
   // Working register port
   input wire logic [2:0] reg_sel_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Indirect access through the first two bank registers
   input wire logic ind_sel_i,
   input wire logic ind_wr_i,
   input wire logic ind_rd_i,
   input wire logic [7:0] ind_wdata_i,
   output logic [7:0] ind_rdata_o,
   // Stack operations
   input wire crb_pkg::crb_stk_op_t stk_op_i,
   input wire logic [7:0] stk_wdata_i,
   input wire logic call_i,
   input wire logic [15:0] ret_addr_i,
   output logic [7:0] stk_rdata_o,
   output logic call_busy_o,
   // State views
   output logic [7:0] stack_top_pointer_o,
   output logic [15:0] data_pointer_o,
   output logic [1:0] bank_select_bits_o
);
   import crb_pkg::*;

   // ********************
   // Registers
   // ********************
   crb_byte_t stack_top_pointer;
   crb_byte_t data_pointer_low_byte;
   crb_byte_t data_pointer_high_byte;
   crb_byte_t program_status_word;
   logic call_second;
   logic [7:0] ret_high;
   logic [1:0] bank_select_bits;

   assign bank_select_bits = program_status_word[`CRB_BANK_MSB:`CRB_BANK_LSB];

   // ********************
   // RAM ports
   // ********************
   logic ram_we;
   logic [7:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic [7:0] ram_raddr_a;
   logic [7:0] ram_rdata_a;
   logic [7:0] ram_raddr_b;
   logic [7:0] ram_rdata_b;
   logic [7:0] ptr_addr;
   logic [7:0] reg_addr;
   logic [7:0] bit_byte_addr;
   logic bit_in_ram;
   logic bit_in_sfr;
   logic sfr_exists;
   logic [7:0] sfr_rd_byte;
   logic [7:0] next_stack_top;
   logic [7:0] next_bit_byte;
   logic [7:0] bit_byte_data;

   // bank base is bank times eight
   assign reg_addr = {3'b000, bank_select_bits, reg_sel_i};
   // first or second indirect pointer of active bank
   assign ptr_addr = {3'b000, bank_select_bits, 2'b00, ind_sel_i};
   // pointer wraps freely, any value allowed
   assign next_stack_top = stack_top_pointer + 8'h01;

   // bit addresses 00h-7Fh map to bytes 20h-2Fh
   assign bit_in_ram = ~bit_addr_i[7];
   assign bit_byte_addr = bit_in_ram ? (`CRB_BITRAM_BASE | {4'h0, bit_addr_i[6:3]}) :
      {bit_addr_i[7:3], 3'b000};

   // Only four SFRs exist; reads anywhere else return zero
   function automatic logic sfr_present(input logic [7:0] a);
      sfr_present = (a == `CRB_ADDR_STACK_TOP) || (a == `CRB_ADDR_DPTR_LOW) ||
         (a == `CRB_ADDR_DPTR_HIGH) || (a == `CRB_ADDR_STATUS);
   endfunction

   // bit addressable only if present and nibble 0 or 8
   assign sfr_exists = sfr_present(bit_byte_addr);
   assign bit_in_sfr = ~bit_in_ram && sfr_exists &&
      ((bit_byte_addr[3:0] == `CRB_NIBBLE_BIT_A) || (bit_byte_addr[3:0] == `CRB_NIBBLE_BIT_B));

   function automatic logic [7:0] sfr_value(input logic [7:0] a, input logic [7:0] stk,
         input logic [7:0] dl, input logic [7:0] dh, input logic [7:0] ps);
      logic [7:0] v;
      v = 8'h00;
      if (a == `CRB_ADDR_STACK_TOP) begin
         v = stk;
      end else if (a == `CRB_ADDR_DPTR_LOW) begin
         v = dl;
      end else if (a == `CRB_ADDR_DPTR_HIGH) begin
         v = dh;
      end else if (a == `CRB_ADDR_STATUS) begin
         v = ps;
      end
      sfr_value = v;
   endfunction

   assign sfr_rd_byte = sfr_value(addr_i, stack_top_pointer, data_pointer_low_byte,
      data_pointer_high_byte, program_status_word);
   assign bit_byte_data = bit_in_ram ? ram_rdata_b :
      sfr_value(bit_byte_addr, stack_top_pointer, data_pointer_low_byte,
      data_pointer_high_byte, program_status_word);

   // Read-modify-write of the byte holding the addressed bit
   always_comb begin
      next_bit_byte = bit_byte_data;
      next_bit_byte[bit_addr_i[2:0]] = bit_wdata_i;
   end

   // ********************
   // RAM write select
   // ********************
   // One write per cycle; priority call > stack > indirect > register > byte > bit
   // Losers are dropped silently, so the decoder must not issue two at once
   always_comb begin
      ram_we = 1'b0;
      ram_waddr = 8'h00;
      ram_wdata = 8'h00;
      if (call_i || call_second) begin
         // return address pushed, low byte first
         ram_we = 1'b1;
         ram_waddr = next_stack_top;
         ram_wdata = call_second ? ret_high : ret_addr_i[7:0];
      end else if (stk_op_i == CRB_STK_PUSH) begin
         ram_we = 1'b1;
         ram_waddr = next_stack_top;
         ram_wdata = stk_wdata_i;
      end else if (ind_wr_i) begin
         ram_we = 1'b1;
         ram_waddr = ram_rdata_a;
         ram_wdata = ind_wdata_i;
      end else if (reg_wr_i) begin
         ram_we = 1'b1;
         ram_waddr = reg_addr;
         ram_wdata = reg_wdata_i;
      end else if (wr_i && ~addr_i[7]) begin
         ram_we = 1'b1;
         ram_waddr = addr_i;
         ram_wdata = wdata_i;
      end else if (bit_wr_i && bit_in_ram) begin
         // bit path needs the bit strobe and a bit address in the scratch-pad
         ram_we = 1'b1;
         ram_waddr = bit_byte_addr;
         ram_wdata = next_bit_byte;
      end
   end

   // ********************
   // RAM read select
   // ********************
   // Port A never depends on RAM data, which keeps the pointer lookup loop free
   always_comb begin
      ram_raddr_a = reg_addr;
      if (stk_op_i == CRB_STK_POP) begin
         // read at current pointer before decrement
         ram_raddr_a = stack_top_pointer;
      end else if (ind_wr_i || ind_rd_i) begin
         ram_raddr_a = ptr_addr;
      end else if (reg_wr_i) begin
         ram_raddr_a = reg_addr;
      end else if (rd_i) begin
         ram_raddr_a = addr_i;
      end
   end

   // Port B serves bit access, or the second step of an indirect read
   always_comb begin
      ram_raddr_b = bit_byte_addr;
      if (ind_rd_i) begin
         // pointed-to byte fetched through port B
         ram_raddr_b = ram_rdata_a;
      end
   end

   // Full byte address space, so both pointers reach every location
   localparam int RAM_DEPTH = 256;
   crb_ram #(
      .DEPTH(RAM_DEPTH)
   ) u_ram (
      .clk_sys_i(clk_sys_i),
      .ce_i(ce_i),
      .we_i(ram_we),
      .waddr_i(ram_waddr),
      .wdata_i(ram_wdata),
      .raddr_a_i(ram_raddr_a),
      .rdata_a_o(ram_rdata_a),
      .raddr_b_i(ram_raddr_b),
      .rdata_b_o(ram_rdata_b)
   );

   // ********************
   // Stack pointer
   // ********************
   // Stack operations outrank a software write to 81h in the same cycle
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stack_top_pointer <= `CRB_RST_STACK_TOP;
      end else if (ce_i) begin
         if (call_i || call_second || stk_op_i == CRB_STK_PUSH) begin
            stack_top_pointer <= next_stack_top;
         end else if (stk_op_i == CRB_STK_POP) begin
            stack_top_pointer <= stack_top_pointer - 8'h01;
         end else if (wr_i && addr_i == `CRB_ADDR_STACK_TOP) begin
            stack_top_pointer <= wdata_i;
         end else if (bit_wr_i && bit_in_sfr && bit_byte_addr == `CRB_ADDR_STACK_TOP) begin
            stack_top_pointer <= next_bit_byte;
         end
      end
   end

   // Two-cycle call push; new calls are ignored while busy
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         call_second <= 1'b0;
         ret_high <= 8'h00;
      end else if (ce_i) begin
         call_second <= call_i && !call_second;
         if (call_i && !call_second) begin
            ret_high <= ret_addr_i[15:8];
         end
      end
   end

   // ********************
   // Data pointer and status word
   // ********************
   // High byte sits at 83h; neither pointer byte is bit addressable
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_pointer_low_byte <= `CRB_RST_DPTR;
         data_pointer_high_byte <= `CRB_RST_DPTR;
      end else if (ce_i) begin
         if (wr_i && addr_i == `CRB_ADDR_DPTR_LOW) begin
            data_pointer_low_byte <= wdata_i;
         end else if (wr_i && addr_i == `CRB_ADDR_DPTR_HIGH) begin
            data_pointer_high_byte <= wdata_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         program_status_word <= `CRB_RST_STATUS;
      end else if (ce_i) begin
         if (wr_i && addr_i == `CRB_ADDR_STATUS) begin
            program_status_word <= wdata_i;
         end else if (bit_wr_i && bit_in_sfr && bit_byte_addr == `CRB_ADDR_STATUS) begin
            program_status_word <= next_bit_byte;
         end
      end
   end

   // ********************
   // Registered outputs
   // ********************
   // Each read result except reg_rdata_o holds until the next read of its kind; reg_rdata_o reloads every cycle
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
         bit_rdata_o <= 1'b0;
         bit_valid_o <= 1'b0;
         reg_rdata_o <= 8'h00;
         ind_rdata_o <= 8'h00;
         stk_rdata_o <= 8'h00;
      end else if (ce_i) begin
         if (rd_i) begin
            rdata_o <= addr_i[7] ? sfr_rd_byte : ram_rdata_a;
         end
         if (bit_rd_i) begin
            // single bit of scratch-pad or SFR
            bit_rdata_o <= bit_byte_data[bit_addr_i[2:0]];
            bit_valid_o <= bit_in_ram || bit_in_sfr;
         end
         reg_rdata_o <= ram_rdata_a;
         if (ind_rd_i) begin
            // data at address held in pointer
            ind_rdata_o <= ram_rdata_b;
         end
         if (stk_op_i == CRB_STK_POP) begin
            stk_rdata_o <= ram_rdata_a;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stack_top_pointer_o <= `CRB_RST_STACK_TOP;
         data_pointer_o <= {`CRB_RST_DPTR, `CRB_RST_DPTR};
         bank_select_bits_o <= 2'b00;
         call_busy_o <= 1'b0;
      end else if (ce_i) begin
         stack_top_pointer_o <= stack_top_pointer;
         // high byte on top, low byte below
         data_pointer_o <= {data_pointer_high_byte, data_pointer_low_byte};
         bank_select_bits_o <= bank_select_bits;
         call_busy_o <= call_i && !call_second;
      end
   end
endmodule

// file: verilog/crb_map.svh
// Offsets, reset values and field positions of the register banks and stack block
`ifndef CRB_MAP_SVH
`define CRB_MAP_SVH
`define CRB_ADDR_STACK_TOP 8'h81
`define CRB_ADDR_DPTR_LOW 8'h82
`define CRB_ADDR_DPTR_HIGH 8'h83
`define CRB_ADDR_STATUS 8'hD0
`define CRB_RST_STACK_TOP 8'h07
`define CRB_RST_DPTR 8'h00
`define CRB_RST_STATUS 8'h00
`define CRB_BANK_LSB 3
`define CRB_BANK_MSB 4
`define CRB_BITRAM_BASE 8'h20
`define CRB_BITRAM_LAST 8'h2F
`define CRB_SFR_BASE 8'h80
`define CRB_NIBBLE_BIT_A 4'h0
`define CRB_NIBBLE_BIT_B 4'h8
`endif

// file: verilog/crb_pkg.sv
// Types shared by the register banks and stack block
package crb_pkg;
   typedef enum logic [1:0] {
      CRB_STK_NONE,
      CRB_STK_PUSH,
      CRB_STK_POP
   } crb_stk_op_t;
   typedef logic [7:0] crb_byte_t;
endpackage

// file: verilog/crb_ram.sv
// Internal scratch-pad RAM held in flip-flops, one write and two read ports
`timescale 1ns/1ns
module crb_ram #(
   parameter int DEPTH = 256
) (
   input wire logic clk_sys_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] raddr_a_i,
   output logic [7:0] rdata_a_o,
   input wire logic [7:0] raddr_b_i,
   output logic [7:0] rdata_b_o
);
   import crb_pkg::*;
   // Address is a full byte, so any other depth leaves holes or aliases
   if (DEPTH != 256) begin : g_depth_check
      $error("crb_ram depth must be 256");
   end
   // ********************
   // Storage
   // ********************
   // No reset: RAM contents survive a core reset
   crb_byte_t mem [DEPTH];
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end
   assign rdata_a_o = mem[raddr_a_i];
   assign rdata_b_o = mem[raddr_b_i];
endmodule

// file: sim/crb_cpu_model.sv
// Model of the instruction logic that issues stack and call requests
`timescale 1ns/1ns
module crb_cpu_model (
   input wire logic clk_sys_i,
   output crb_pkg::crb_stk_op_t stk_op_o,
   output logic [7:0] stk_wdata_o,
   output logic call_o,
   output logic [15:0] ret_addr_o
);
   import crb_pkg::*;
   initial begin
      stk_op_o = CRB_STK_NONE;
      stk_wdata_o = 8'h00;
      call_o = 1'b0;
      ret_addr_o = 16'h0000;
   end
   // Requests held over one edge; data inverted when released, never left stale
   task automatic push(input logic [7:0] v);
      @(posedge clk_sys_i);
      stk_op_o <= CRB_STK_PUSH;
      stk_wdata_o <= v;
   endtask
   task automatic pop();
      @(posedge clk_sys_i);
      stk_op_o <= CRB_STK_POP;
      stk_wdata_o <= ~stk_wdata_o;
   endtask
   task automatic idle();
      @(posedge clk_sys_i);
      stk_op_o <= CRB_STK_NONE;
      stk_wdata_o <= ~stk_wdata_o;
   endtask
   task automatic call(input logic [15:0] v);
      @(posedge clk_sys_i);
      call_o <= 1'b1;
      ret_addr_o <= v;
      @(posedge clk_sys_i);
      call_o <= 1'b0;
      ret_addr_o <= ~v;
   endtask
endmodule

// file: sim/crb_core_regs_checker.sv
// Port assertions for the register banks and stack block
`timescale 1ns/1ns
module crb_core_regs_checker (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [7:0] bit_addr_i,
   input wire logic bit_rd_i,
   input wire logic bit_valid_o,
   input wire crb_pkg::crb_stk_op_t stk_op_i,
   input wire logic [7:0] stk_wdata_i,
   input wire logic call_i,
   input wire logic call_busy_o,
   input wire logic [7:0] stk_rdata_o,
   input wire logic [7:0] stack_top_pointer_o,
   input wire logic [15:0] data_pointer_o,
   input wire logic [1:0] bank_select_bits_o
);
   import crb_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic quiet;
   logic bit_ok;
   logic [1:0] wr_bank;
   // Views lag one cycle, so every stack pointer step is compared against the view itself
   assign quiet = ce_i && !call_i && !call_busy_o && !wr_i;
   assign bit_ok = !bit_addr_i[7] || bit_addr_i[7:3] == 5'h1A;
   assign wr_bank = wdata_i[4:3];
   a_push_incr: assert property (
      quiet && stk_op_i == CRB_STK_PUSH ##1 ce_i |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01)
      else $error("push did not add one to the stack pointer");
   a_pop_decr: assert property (
      quiet && stk_op_i == CRB_STK_POP ##1 ce_i |=> stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h01)
      else $error("pop did not take one from the stack pointer");
   a_push_pop_data: assert property (
      quiet && stk_op_i == CRB_STK_PUSH ##1 ce_i && stk_op_i == CRB_STK_POP |=> stk_rdata_o == $past(stk_wdata_i, 2))
      else $error("pop after push returned other data");
   a_call_two: assert property (
      ce_i && call_i && !call_busy_o && !wr_i ##1 ce_i [*2] |=>
      stack_top_pointer_o == $past(stack_top_pointer_o, 2) + 8'h02)
      else $error("call did not advance the stack pointer by two");
   a_stack_reset: assert property ($fell(sys_rst_i) |-> stack_top_pointer_o == 8'h07)
      else $error("stack pointer not at its reset value");
   a_stack_read: assert property (ce_i && rd_i && addr_i == 8'h81 |=> rdata_o == stack_top_pointer_o)
      else $error("stack pointer read differs from its view");
   a_dptr_low_read: assert property (ce_i && rd_i && addr_i == 8'h82 |=> rdata_o == data_pointer_o[7:0])
      else $error("data pointer low read differs from its view");
   a_freeze_views: assert property (
      !ce_i |=> $stable(stack_top_pointer_o) && $stable(rdata_o) && $stable(bank_select_bits_o))
      else $error("state moved while the clock enable was low");
   a_bit_valid: assert property (ce_i && bit_rd_i |=> bit_valid_o == $past(bit_ok))
      else $error("bit valid flag wrong for this bit address");
   a_bank_follow: assert property (
      ce_i && wr_i && addr_i == 8'hD0 ##1 ce_i |=> bank_select_bits_o == $past(wr_bank, 2))
      else $error("bank select view does not follow status write");
endmodule
bind crb_core_regs crb_core_regs_checker u_chk (.clk_sys_i, .sys_rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .bit_addr_i, .bit_rd_i, .bit_valid_o, .stk_op_i, .stk_wdata_i, .call_i, .call_busy_o, .stk_rdata_o,
   .stack_top_pointer_o, .data_pointer_o, .bank_select_bits_o);

// file: sim/crb_core_regs_test.sv
// Self-checking testbench for the register banks and stack block
`timescale 1ns/1ns
module crb_core_regs_test;
   import crb_pkg::*;
   localparam int WR = 0, RD = 1, BWR = 2, BRD = 3, RWR = 4, IWR = 5, IRD = 6, NOP = 7;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [7:0] a = 8'h00;
   logic [7:0] d = 8'h00;
   logic [6:0] stb = 7'h00;
   logic [7:0] rdata, reg_rdata, ind_rdata, stk_rdata, stk_top, stk_wdata;
   logic bit_rdata, bit_valid, busy, call;
   logic [15:0] dptr, ret;
   logic [1:0] bank;
   crb_stk_op_t stk_op;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   initial forever #10 clk_sys_i = ~clk_sys_i;
   crb_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .stk_op_o(stk_op), .stk_wdata_o(stk_wdata), .call_o(call),
      .ret_addr_o(ret));
   crb_core_regs DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(a), .wdata_i(d),
      .wr_i(stb[0]), .rd_i(stb[1]), .rdata_o(rdata), .bit_addr_i(a), .bit_wr_i(stb[2]), .bit_rd_i(stb[3]),
      .bit_wdata_i(d[0]), .bit_rdata_o(bit_rdata), .bit_valid_o(bit_valid), .reg_sel_i(a[2:0]),
      .reg_wr_i(stb[4]), .reg_wdata_i(d), .reg_rdata_o(reg_rdata), .ind_sel_i(a[0]), .ind_wr_i(stb[5]),
      .ind_rd_i(stb[6]), .ind_wdata_i(d), .ind_rdata_o(ind_rdata), .stk_op_i(stk_op), .stk_wdata_i(stk_wdata),
      .call_i(call), .ret_addr_i(ret), .stk_rdata_o(stk_rdata), .call_busy_o(busy), .stack_top_pointer_o(stk_top),
      .data_pointer_o(dptr), .bank_select_bits_o(bank));
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // One strobe per call (none for NOP), dropped a cycle later; results looked at mid-cycle
   task automatic go(input logic [7:0] ad, input logic [7:0] dd, input int k);
      @(posedge clk_sys_i);
      a <= ad;
      d <= dd;
      stb <= 7'(1 << k);
      @(posedge clk_sys_i);
      stb <= 7'h00;
      @(negedge clk_sys_i);
   endtask
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      chk("stack view", 16'(stk_top), 16'h0007);
      go(8'h81, 8'h00, RD);
      chk("stack read", 16'(rdata), 16'h0007);
      go(8'h81, 8'hF0, WR);
      go(8'h81, 8'h00, RD);
      chk("stack any", 16'(rdata), 16'h00F0);
      $display("test reset done");
      go(8'h82, 8'h5A, WR);
      go(8'h83, 8'hC3, WR);
      go(8'h82, 8'h00, RD);
      chk("dptr low", 16'(rdata), 16'h005A);
      chk("dptr", dptr, 16'hC35A);
      go(8'h84, 8'h00, RD);
      chk("unmapped", 16'(rdata), 16'h0000);
      $display("test pointer done");
      go(8'h81, 8'h30, WR);
      u_cpu.push(8'hA1);
      u_cpu.push(8'hB2);
      u_cpu.pop();
      u_cpu.idle();
      @(negedge clk_sys_i);
      chk("pop b2", 16'(stk_rdata), 16'h00B2);
      u_cpu.pop();
      u_cpu.idle();
      @(negedge clk_sys_i);
      chk("pop a1", 16'(stk_rdata), 16'h00A1);
      go(8'h31, 8'h00, RD);
      chk("ram 31", 16'(rdata), 16'h00A1);
      go(8'h81, 8'h00, RD);
      chk("stack back", 16'(rdata), 16'h0030);
      go(8'h81, 8'h40, WR);
      u_cpu.call(16'h1234);
      @(negedge clk_sys_i);
      chk("call busy", 16'(busy), 16'h0001);
      go(8'h41, 8'h00, RD);
      chk("ret low", 16'(rdata), 16'h0034);
      chk("call idle", 16'(busy), 16'h0000);
      go(8'h42, 8'h00, RD);
      chk("ret high", 16'(rdata), 16'h0012);
      chk("stack call", 16'(stk_top), 16'h0042);
      $display("test stack done");
      for (int b = 0; b < 4; b++) begin
         go(8'hD0, 8'(b << 3), WR);
         go(8'h01, 8'(8'h48 + b), RWR);
      end
      for (int b = 0; b < 4; b++) begin
         go(8'hD0, 8'(b << 3), WR);
         go(8'h01, 8'h00, NOP);
         chk("bank reg", 16'(reg_rdata), 16'(8'h48 + b));
         go(8'(b * 8 + 1), 8'h00, RD);
         chk("bank ram", 16'(rdata), 16'(8'h48 + b));
      end
      go(8'h01, 8'h77, IWR);
      go(8'h4B, 8'h00, RD);
      chk("ind wr", 16'(rdata), 16'h0077);
      go(8'h01, 8'h00, IRD);
      chk("ind rd", 16'(ind_rdata), 16'h0077);
      go(8'h00, 8'h50, RWR);
      go(8'h00, 8'h66, IWR);
      go(8'h50, 8'h00, RD);
      chk("ind0 wr", 16'(rdata), 16'h0066);
      go(8'h00, 8'h00, IRD);
      chk("ind0 rd", 16'(ind_rdata), 16'h0066);
      $display("test banks done");
      go(8'h21, 8'h00, WR);
      go(8'h2F, 8'h00, WR);
      go(8'h0B, 8'h01, BWR);
      go(8'h7F, 8'h01, BWR);
      go(8'h21, 8'h00, RD);
      chk("bit 21", 16'(rdata), 16'h0008);
      go(8'h2F, 8'h00, RD);
      chk("bit 2f", 16'(rdata), 16'h0080);
      go(8'h0B, 8'h00, BRD);
      chk("bit rd", {14'h0000, bit_valid, bit_rdata}, 16'h0003);
      go(8'h81, 8'h01, BRD);
      chk("bit none", {15'h0000, bit_valid}, 16'h0000);
      go(8'hD0, 8'h00, WR);
      go(8'hD3, 8'h01, BWR);
      go(8'h00, 8'h00, NOP);
      chk("bit sfr", {14'h0000, bank}, 16'h0001);
      $display("test bits done");
      @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      chk("stack rst", 16'(stk_top), 16'h0007);
      chk("dptr rst", dptr, 16'h0000);
      go(8'h81, 8'h00, RD);
      chk("stack rd rst", 16'(rdata), 16'h0007);
      go(8'h4B, 8'h00, RD);
      chk("ram kept", 16'(rdata), 16'h0077);
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      go(8'h81, 8'h55, WR);
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      go(8'h81, 8'h00, RD);
      chk("ce freeze", 16'(rdata), 16'h0007);
      $display("test second reset done");
      stop_test();
   end
endmodule
